// *** logic/ebm_seq.sv ***
// Overview of operation
// - wide operands split into 2..16 port transfers
// - first clock drives address, type, direction, start
// - size outputs show port width when splitting
// - direction low in first clock of writes
// - second clock: start off, privilege, data driven
// - sample sync ack each edge, hold data
// - next transfer: advance address, restart, code/data
// - release data bus after final acknowledged write
// - async ack ends all but DRAM transfers
// - async ack synchronized before ending a transfer
// - error ack during synchronizing ends in error
// - write data held until the terminating ack (sync, synchronized async or error)
// - async ack first asserted in the second clock gives one wait state
// - byte read from 8-bit port takes top lane
// - keep sampling, insert waits while ack negated
// - direction high in first clock of reads
// - access kind low for user in second clock
`timescale 1ns/100ps
`default_nettype none
`include "ebm_map.svh"

module ebm_seq (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic req_valid,
   input wire ebm_pkg::ebm_req_t req,
   output logic req_ready,
   output logic rsp_valid,
   output ebm_pkg::ebm_rsp_t rsp,
   output logic [`EBM_ADDR_W-1:0] bus_addr,
   output logic [1:0] xfer_type,
   output logic [1:0] xfer_size,
   output logic rd_wr,
   output logic access_kind,
   output logic xfer_start_n,
   output logic [`EBM_BUS_W-1:0] data_out,
   output logic data_oe,
   input wire logic [`EBM_BUS_W-1:0] data_in,
   input wire logic sync_xfer_ack_n,
   input wire logic async_xfer_ack_n,
   input wire logic xfer_err_ack_n
);

   ebm_pkg::ebm_state_t state;
   logic [4:0] beats_left;
   logic [2:0] step_lg;
   logic [5:0] step_bits;
   logic write;
   logic supervisor;
   logic is_code;
   logic is_dram;
   logic [`EBM_OPER_W-1:0] wshift;
   logic [`EBM_OPER_W-1:0] rshift;
   logic ack_int;

   logic accept;
   logic ack_sync;
   logic ack_async;
   logic err;
   logic term;
   logic last;
   logic [2:0] req_op_lg;
   logic [2:0] req_pt_lg;
   logic [2:0] req_x_lg;
   logic [7:0] req_op_bits;
   logic [`EBM_OPER_W-1:0] next_wshift;
   logic [`EBM_OPER_W-1:0] next_rshift;
   logic [`EBM_OPER_W-1:0] lane;
   logic [`EBM_ADDR_W-1:0] step_bytes;

   function automatic logic [2:0] siz_lg(input logic [1:0] code);
      case (code)
         `EBM_SIZ_BYTE: siz_lg = `EBM_LG_BYTE;
         `EBM_SIZ_WORD: siz_lg = `EBM_LG_WORD;
         `EBM_SIZ_LONG: siz_lg = `EBM_LG_LONG;
         default: siz_lg = `EBM_LG_LINE;
      endcase
   endfunction

   // the acknowledge pin is asynchronous; only its synchronized form is used
   ebm_ack_sync u_ack_sync (
      .clk(clk),
      .rst_n(rst_n),
      .async_xfer_ack_n(async_xfer_ack_n),
      .ack_int(ack_int)
   );

   // request decode
   always_comb begin
      req_op_lg = siz_lg(req.oper_size);
      req_pt_lg = siz_lg(req.port_size);
      req_x_lg = (req_op_lg > req_pt_lg) ? req_pt_lg : req_op_lg;
      req_op_bits = `EBM_BYTE_BITS << req_op_lg;
   end

   assign req_ready = (state == ebm_pkg::st_idle);
   assign accept = req_valid && req_ready;

   // termination decode; every strobe on the bus is active low
   assign ack_sync = ~sync_xfer_ack_n;
   assign ack_async = ack_int && !is_dram;
   assign err = ~xfer_err_ack_n;
   assign term = (state == ebm_pkg::st_wait) && (ack_sync || ack_async || err);
   assign last = (beats_left == `EBM_BEAT_ONE) || err;

   // data path helpers
   assign step_bytes = `EBM_ADDR_W'(1) << step_lg;
   assign next_wshift = wshift << step_bits;
   assign lane = {{(`EBM_OPER_W-`EBM_BUS_W){1'b0}}, data_in >> (`EBM_BUS_BITS - step_bits)};
   assign next_rshift = (rshift << step_bits) | lane;

   // sequencer
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state <= ebm_pkg::st_idle;
      end else begin
         case (state)
            ebm_pkg::st_idle: begin
               if (accept) begin
                  state <= ebm_pkg::st_start;
               end
            end
            ebm_pkg::st_start: begin
               state <= ebm_pkg::st_wait;
            end
            ebm_pkg::st_wait: begin
               if (term) begin
                  state <= last ? ebm_pkg::st_idle : ebm_pkg::st_start;
               end
            end
            default: begin
               state <= ebm_pkg::st_idle;
            end
         endcase
      end
   end

   // beat count: operand bytes over port bytes, one when port is wider
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         beats_left <= 5'h00;
         step_lg <= 3'h0;
         step_bits <= 6'h00;
      end else if (accept) begin
         beats_left <= `EBM_BEAT_ONE << (req_op_lg - req_x_lg);
         step_lg <= req_x_lg;
         step_bits <= 6'(`EBM_BYTE_BITS << req_x_lg);
      end else if (term && !last) begin
         beats_left <= beats_left - `EBM_BEAT_ONE;
      end
   end

   // transfer attributes held for the whole operand
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         write <= 1'b0;
         supervisor <= 1'b0;
         is_code <= 1'b0;
         is_dram <= 1'b0;
         xfer_type <= 2'h0;
         xfer_size <= `EBM_SIZ_LONG;
         rd_wr <= 1'b1;
      end else if (accept) begin
         write <= req.write;
         supervisor <= req.supervisor;
         is_code <= req.is_code;
         is_dram <= req.is_dram;
         xfer_type <= req.xfer_type;
         xfer_size <= (req_op_lg > req_pt_lg) ? req.port_size : req.oper_size;
         rd_wr <= ~req.write;
      end
   end

   // address: next port-sized unit after each acknowledged transfer
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         bus_addr <= '0;
      end else if (accept) begin
         bus_addr <= req.addr;
      end else if (term && !last) begin
         bus_addr <= bus_addr + step_bytes;
      end
   end

   // start strobe for one clock, then privilege in the remaining clocks
   assign xfer_start_n = ~(state == ebm_pkg::st_start);
   always_comb begin
      case (state)
         ebm_pkg::st_start: access_kind = is_code;
         ebm_pkg::st_wait: access_kind = supervisor;
         default: access_kind = 1'b0;
      endcase
   end

   // write data: most significant part first, held through waits
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wshift <= '0;
         data_out <= '0;
      end else if (accept) begin
         wshift <= req.wdata << (`EBM_OPER_BITS - req_op_bits);
         data_out <= `EBM_BUS_W'((req.wdata << (`EBM_OPER_BITS - req_op_bits)) >> (`EBM_OPER_W - `EBM_BUS_W));
      end else if (term && !last) begin
         wshift <= next_wshift;
         data_out <= next_wshift[`EBM_OPER_W-1 -: `EBM_BUS_W];
      end
   end

   // drive enable: on from the second clock, off after the final ack
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         data_oe <= 1'b0;
      end else if (term && last) begin
         data_oe <= 1'b0;
      end else if (state == ebm_pkg::st_start && write) begin
         data_oe <= 1'b1;
      end
   end

   // read data capture on the terminating edge
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rshift <= '0;
      end else if (accept) begin
         rshift <= '0;
      end else if (term && !err && !write) begin
         rshift <= next_rshift;
      end
   end

   // completion
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rsp_valid <= 1'b0;
         rsp <= '0;
      end else begin
         rsp_valid <= term && last;
         if (term && last) begin
            rsp.err <= err;
            rsp.rdata <= (write || err) ? rshift : next_rshift;
         end
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   chk_beat_range: assert property ((state != ebm_pkg::st_idle) |->
      (beats_left >= `EBM_BEAT_ONE) && (beats_left <= `EBM_BEAT_MAX))
      else $error("beat count out of range");

   chk_first_clock: assert property (accept |=>
      !xfer_start_n && (bus_addr == $past(req.addr)) && (xfer_type == $past(req.xfer_type)))
      else $error("first clock attributes wrong");

   chk_split_size: assert property ((accept && req.oper_size == `EBM_SIZ_LONG
      && req.port_size == `EBM_SIZ_WORD) |=> (xfer_size == `EBM_SIZ_WORD))
      else $error("longword to word port not sized as word");

   chk_direction: assert property (accept |=> (rd_wr == !$past(req.write)))
      else $error("direction output wrong in first clock");

   chk_second_clock: assert property (!xfer_start_n |=>
      xfer_start_n && (access_kind == supervisor) && (data_oe == write))
      else $error("second clock outputs wrong");

   chk_wait_hold: assert property ((state == ebm_pkg::st_wait && !term) |=>
      (state == ebm_pkg::st_wait) && $stable(data_out) && $stable(bus_addr))
      else $error("wait state not held");

   chk_next_beat: assert property ((term && !last) |=>
      !xfer_start_n && (bus_addr == $past(bus_addr) + step_bytes))
      else $error("next transfer not started at next address");

   chk_bus_release: assert property ((term && last) |=> !data_oe ##1 !data_oe)
      else $error("data bus not released after final transfer");

   chk_dram_ignore: assert property ((state == ebm_pkg::st_wait && is_dram
      && sync_xfer_ack_n && xfer_err_ack_n) |=> (state == ebm_pkg::st_wait))
      else $error("dram transfer ended without synchronous ack");

   chk_err_wins: assert property ((state == ebm_pkg::st_wait && err) |=>
      (state == ebm_pkg::st_idle) && rsp_valid && rsp.err)
      else $error("error ack did not end transfer in error");

   chk_write_held: assert property ((state == ebm_pkg::st_wait && write) |-> data_oe)
      else $error("write data released before ack");

   chk_read_dir: assert property ((accept && !req.write) |=> rd_wr)
      else $error("direction not high in first clock of read");

   chk_user_mode: assert property ((!xfer_start_n && !supervisor) |=> !access_kind)
      else $error("access kind not low for user access");

   chk_top_lane: assert property ((term && last && !err && !write && xfer_size == `EBM_SIZ_BYTE) |=>
      (rsp.rdata[`EBM_BYTE_BITS-1:0] == $past(data_in[`EBM_BUS_W-1 -: `EBM_BYTE_BITS])))
      else $error("byte read not taken from top lane");

endmodule

`default_nettype wire

// *** logic/ebm_map.svh ***
`ifndef EBM_MAP_SVH
`define EBM_MAP_SVH

// size encodings on the bus and in requests
`define EBM_SIZ_LONG 2'h0
`define EBM_SIZ_BYTE 2'h1
`define EBM_SIZ_WORD 2'h2
`define EBM_SIZ_LINE 2'h3

// log2 of the byte count of each size
`define EBM_LG_BYTE 3'h0
`define EBM_LG_WORD 3'h1
`define EBM_LG_LONG 3'h2
`define EBM_LG_LINE 3'h4

// widths
`define EBM_ADDR_W 28
`define EBM_BUS_W 32
`define EBM_OPER_W 128

// bit counts used in shift arithmetic
`define EBM_BUS_BITS 6'h20
`define EBM_OPER_BITS 8'h80
`define EBM_BYTE_BITS 8'h08

// beat limits
`define EBM_BEAT_ONE 5'h01
`define EBM_BEAT_MAX 5'h10

`endif

// *** logic/ebm_pkg.sv ***
`include "ebm_map.svh"

package ebm_pkg;

   typedef enum logic [1:0] {
      st_idle,
      st_start,
      st_wait
   } ebm_state_t;

   typedef struct packed {
      logic [`EBM_ADDR_W-1:0] addr;
      logic write;
      logic [1:0] oper_size;
      logic [1:0] port_size;
      logic [1:0] xfer_type;
      logic supervisor;
      logic is_code;
      logic is_dram;
      logic [`EBM_OPER_W-1:0] wdata;
   } ebm_req_t;

   typedef struct packed {
      logic [`EBM_OPER_W-1:0] rdata;
      logic err;
   } ebm_rsp_t;

endpackage

// *** logic/ebm_ack_sync.sv ***
`timescale 1ns/100ps
`default_nettype none

module ebm_ack_sync (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic async_xfer_ack_n,
   output logic ack_int
);

   logic stage1;

   // both stages on the falling edge: an acknowledge seen at the falling
   // edge of one clock is internal by the rising edge ending the next
   always_ff @(negedge clk) begin
      if (!rst_n) begin
         stage1 <= 1'b0;
         ack_int <= 1'b0;
      end else begin
         stage1 <= ~async_xfer_ack_n;
         ack_int <= stage1;
      end
   end

   chk_sync_latency: assert property (@(negedge clk) disable iff (!rst_n)
      !async_xfer_ack_n |-> ##2 ack_int)
      else $error("internal ack not asserted two falling edges after async ack");

endmodule

`default_nettype wire

// *** sim/ebm_slave.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "ebm_map.svh"

module ebm_slave (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [2:0] mode,
   input wire logic [3:0] waits,
   input wire logic xfer_start_n,
   input wire logic rd_wr,
   input wire logic [`EBM_ADDR_W-1:0] bus_addr,
   output logic [`EBM_BUS_W-1:0] data_in,
   output logic sync_xfer_ack_n,
   output logic async_xfer_ack_n,
   output logic xfer_err_ack_n
);
   int n;
   logic aq;
   initial begin
      n = 99;
      aq = 1'b1;
      data_in = '0;
      sync_xfer_ack_n = 1'b1;
      xfer_err_ack_n = 1'b1;
   end
   // mode: 0 sync, 1 async, 2 error while async is synchronizing, 3 async held plus sync, 4 async tied low
   // n counts clocks after the start strobe, 0 being the second clock
   always @(posedge clk) begin
      if (!rst_n) n = 99;
      else if (!xfer_start_n) n = 0;
      else if (n < 99) n = n + 1;
      sync_xfer_ack_n <= !((mode == 3'h0 || mode == 3'h3) && n == waits);
      aq <= !((mode inside {3'h1, 3'h2} && n >= waits && n <= waits + 1) || (mode == 3'h3 && n <= waits));
      xfer_err_ack_n <= !(mode == 3'h2 && n == waits);
      // read data held through the synchronizing clock, scrambled otherwise
      if (rd_wr && n >= waits && n <= waits + 1) data_in <= {bus_addr[7:0] ^ 8'h5a, bus_addr[7:0], ~bus_addr[7:0], 8'hc3};
      else data_in <= ~data_in;
   end
   assign async_xfer_ack_n = (mode == 3'h4) ? 1'b0 : aq;
endmodule
`default_nettype wire

// *** sim/ext_bus_multi_beat_async_ack_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "ebm_map.svh"

module ext_bus_multi_beat_async_ack_tb;
   typedef struct {
      int lat, beats, t0, lw;
      logic err, wr, code, sup;
      logic [1:0] sz, tt;
      logic [127:0] rd;
   } ebm_rec_t;
   typedef struct {
      logic [27:0] addr;
      logic [31:0] chunk;
   } ebm_beat_t;
   logic clk, rst_n, req_valid, req_ready, rsp_valid, xfer_start_n, rd_wr, access_kind, data_oe;
   logic sync_xfer_ack_n, async_xfer_ack_n, xfer_err_ack_n;
   ebm_pkg::ebm_req_t req;
   ebm_pkg::ebm_rsp_t rsp;
   logic [27:0] bus_addr;
   logic [1:0] xfer_type, xfer_size;
   logic [31:0] data_out, data_in, seed, cb, r;
   logic [2:0] md;
   logic [3:0] pw;
   int n_fail, samples_checked, cyc, nb, i, t;
   ebm_rec_t rec[$];
   ebm_beat_t bq[$];

   ebm_seq ebm_seq_i (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req(req), .req_ready(req_ready),
      .rsp_valid(rsp_valid), .rsp(rsp), .bus_addr(bus_addr), .xfer_type(xfer_type), .xfer_size(xfer_size),
      .rd_wr(rd_wr), .access_kind(access_kind), .xfer_start_n(xfer_start_n), .data_out(data_out),
      .data_oe(data_oe), .data_in(data_in), .sync_xfer_ack_n(sync_xfer_ack_n),
      .async_xfer_ack_n(async_xfer_ack_n), .xfer_err_ack_n(xfer_err_ack_n));
   ebm_slave ebm_slave_i (.clk(clk), .rst_n(rst_n), .mode(md), .waits(pw), .xfer_start_n(xfer_start_n),
      .rd_wr(rd_wr), .bus_addr(bus_addr), .data_in(data_in), .sync_xfer_ack_n(sync_xfer_ack_n),
      .async_xfer_ack_n(async_xfer_ack_n), .xfer_err_ack_n(xfer_err_ack_n));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   function automatic logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction

   task automatic check(input logic [127:0] seen, input logic [127:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // queue the expected beats, hold the request until taken, then arm the slave
   task automatic op(input logic wr, input logic [1:0] os, input logic [1:0] ps, input logic [2:0] m,
                     input logic [3:0] w, input logic code, input logic sup, input logic dram);
      ebm_pkg::ebm_req_t q;
      ebm_rec_t e;
      ebm_beat_t b;
      int pb, ob, k, n;
      pb = (ps == 2'h1) ? 1 : (ps == 2'h2) ? 2 : 4;
      ob = (os == 2'h1) ? 1 : (os == 2'h2) ? 2 : (os == 2'h0) ? 4 : 16;
      q = '0;
      q.addr = 28'(rnd() << 4);
      q.write = wr;
      q.oper_size = os;
      q.port_size = ps;
      q.xfer_type = 2'(rnd());
      q.supervisor = sup;
      q.is_code = code;
      q.is_dram = dram;
      q.wdata = {rnd(), rnd(), rnd(), rnd()} >> (128 - ob * 8);
      e.beats = (ob > pb) ? ob / pb : 1;
      e.lw = ((ob > pb) ? pb : ob) * 8;
      e.sz = (ob > pb) ? ps : os;
      e.wr = wr;
      e.code = code;
      e.sup = sup;
      e.tt = q.xfer_type;
      e.err = (m == 3'h2);
      e.rd = '0;
      e.lat = (m == 3'h2) ? 3 + w : (m == 3'h4) ? e.beats * 2 + 1 : e.beats * (2 + w + (m == 3'h1)) + 1;
      for (k = 0; k < e.beats; k++) begin
         b.addr = q.addr + 28'(k * pb);
         b.chunk = 32'(q.wdata >> ((e.beats - 1 - k) * e.lw)) << (32 - e.lw);
         e.rd = (e.rd << e.lw) | 128'({b.addr[7:0] ^ 8'h5a, b.addr[7:0], ~b.addr[7:0], 8'hc3} >> (32 - e.lw));
         bq.push_back(b);
      end
      req <= q;
      req_valid <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (req_ready !== 1'b1 && n < 300);
      if (n >= 300) n_fail++;
      e.t0 = cyc;
      rec.push_back(e);
      md <= m;
      pw <= w;
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (rst_n === 1'b1 && rec.size() > 0) begin
         if (xfer_start_n === 1'b0) begin
            check(bus_addr, bq[0].addr);
            check(xfer_size, rec[0].sz);
            check(rd_wr, !rec[0].wr);
            check(xfer_type, rec[0].tt);
            check(access_kind, rec[0].code);
            cb = bq[0].chunk;
            bq.delete(0);
            nb++;
         end else if (rsp_valid === 1'b1) begin
            check(cyc - rec[0].t0, rec[0].lat);
            check(rsp.err, rec[0].err);
            check(data_oe, 1'b0);
            check(nb, rec[0].beats);
            if (!rec[0].wr) check(rsp.rdata, rec[0].rd);
            $display("op finished at %0t", $time);
            nb = 0;
            rec.delete(0);
         end else if (req_ready === 1'b0) begin
            check(access_kind, rec[0].sup);
            check(data_oe, rec[0].wr);
            if (rec[0].wr) check(data_out & ~(32'hffffffff >> rec[0].lw), cb);
         end
      end
   end

   initial begin
      repeat (6000) @(posedge clk);
      n_fail++;
      tally_and_finish();
   end

   initial begin
      rst_n = 1'b0;
      req_valid = 1'b0;
      req = '0;
      md = 3'h0;
      pw = 4'h0;
      seed = 32'hb7a62eb9;
      n_fail = 0;
      samples_checked = 0;
      cyc = 0;
      nb = 0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      op(1'b1, 2'h0, 2'h2, 3'h0, 4'h0, 1'b0, 1'b1, 1'b0);
      op(1'b1, 2'h3, 2'h1, 3'h0, 4'h1, 1'b0, 1'b0, 1'b0);
      op(1'b0, 2'h1, 2'h1, 3'h1, 4'h0, 1'b1, 1'b0, 1'b0);
      op(1'b0, 2'h0, 2'h2, 3'h1, 4'h2, 1'b0, 1'b1, 1'b0);
      op(1'b1, 2'h1, 2'h0, 3'h1, 4'h1, 1'b0, 1'b0, 1'b0);
      op(1'b1, 2'h2, 2'h2, 3'h2, 4'h0, 1'b0, 1'b1, 1'b0);
      op(1'b0, 2'h0, 2'h0, 3'h3, 4'h3, 1'b0, 1'b1, 1'b1);
      op(1'b0, 2'h2, 2'h1, 3'h4, 4'h0, 1'b1, 1'b1, 1'b0);
      for (i = 0; i < 6; i++) begin
         r = rnd();
         op(r[0], r[2:1], (r[4:3] == 2'h3) ? 2'h2 : r[4:3], {2'h0, r[5]}, 4'(r[7:6]), r[8], r[9], 1'b0);
      end
      req_valid <= 1'b0;
      t = 0;
      while (rec.size() > 0 && t < 500) begin
         @(posedge clk);
         t++;
      end
      if (t >= 500) n_fail++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
